// *** hdl/tlic_arbiter.sv ***
// fixed polling-order pick among the requests of one level
`default_nettype none
module tlic_arbiter #(
   parameter int N = tlic_pkg::NSRC
) (
   input  wire logic [N-1:0]               mask_i,
   output logic                            valid_o,
   output logic [tlic_pkg::SRC_W-1:0]      idx_o
);
   if (N != tlic_pkg::NSRC) begin : g_chk
      $error("arbiter width must match the polling table");
   end

   // walk the table backwards so the earliest entry is the last to write and wins
   always_comb begin
      valid_o = 1'b0;
      idx_o   = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (mask_i[tlic_pkg::POLL[i]]) begin
            valid_o = 1'b1;
            idx_o   = tlic_pkg::POLL[i];
         end
      end
   end
endmodule // tlic_arbiter
`default_nettype wire

// *** hdl/tlic_pkg.sv ***
// shared constants and types of the two-level interrupt controller
`default_nettype none
package tlic_pkg;
   localparam int NSRC  = 12;
   localparam int SRC_W = 4;
   localparam logic [SRC_W-1:0] SRC_PD = 4'hc;

   // dispatch addresses, indexed by source number (12 = power-down wake-up)
   localparam logic [15:0] VEC [0:NSRC] = '{
      16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0023, 16'h002b, 16'h0043,
      16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b, 16'h007b};

   // polling order inside one level, first entry wins
   localparam logic [SRC_W-1:0] POLL [0:NSRC-1] = '{
      4'h0, 4'h6, 4'h1, 4'h7, 4'h2, 4'h8, 4'h3, 4'h9, 4'h4, 4'ha, 4'h5, 4'hb};

   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_LEVEL  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_VECTOR = 8'h10;

   localparam int EN_GLOBAL_BIT  = 12;
   localparam int MODE_IDLE_BIT  = 0;
   localparam int MODE_PD_BIT    = 1;
   localparam int MODE_WAKE_BIT  = 2;
   localparam int ST_PD_BIT      = 12;
   localparam int ST_ACT_LO_BIT  = 16;
   localparam int ST_ACT_HI_BIT  = 17;

   localparam logic [NSRC-1:0] ENABLE_RST = 12'h000;
   localparam logic            GLOBAL_RST = 1'b0;
   localparam logic [NSRC-1:0] LEVEL_RST  = 12'h000;

   localparam int CLK_PERIOD_NS = 4;
   localparam int STAB_TIME_MS  = 1;
   localparam int STAB_CYCLES   = STAB_TIME_MS * 1000000 / CLK_PERIOD_NS;

   typedef enum logic [4:0] {
      M_RUN  = 5'b00001,
      M_IDLE = 5'b00010,
      M_PD   = 5'b00100,
      M_OSC  = 5'b01000,
      M_STAB = 5'b10000
   } tlic_mode_e;

   typedef enum logic [1:0] {
      D_WAIT = 2'b01,
      D_REQ  = 2'b10
   } tlic_disp_e;
endpackage
`default_nettype wire

// *** hdl/tlic_sync.sv ***
// two-flop synchroniser for a level from outside the clock domain
`default_nettype none
module tlic_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input  wire logic sys_clk_i,
   input  wire logic reset_n_i,
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta_reg;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_reg <= RESET_VAL;
         sync_o   <= RESET_VAL;
      end else begin
         meta_reg <= async_i;
         sync_o   <= meta_reg;
      end
   end
endmodule // tlic_sync
`default_nettype wire

// *** hdl/tlic_top.sv ***
// two-level interrupt controller with apb registers and power-mode sequencing
// Functional notes
// - twelve sources, each set to high or low level.
// - high request preempts an active low routine; low requests wait.
// - an active high routine is never preempted.
// - simultaneous requests of both levels: high level is granted.
// - within a level a fixed polling order picks the winner.
// - order ext0, converter, timer0, ext2, ext1, emergency, timer1, ct2, serial, match...
// - each source has a fixed dispatch address, power-down wake at 007b.
// - serial, timer2, emergency, match, compare timer 1 are ORs of flags.
// - pin-0 low wake from power-down dispatches the wake-up vector.
// - in idle the controller runs; an enabled request ends idle.
// - after pin wake wait for oscillator, then about 1 ms.
// - ending a power mode by interrupt keeps all state.
//
// The placing of the registers and the APB interface to the registers were chosen for this implementation.
`default_nettype none
module tlic_top #(
   parameter int STAB_CYCLES = tlic_pkg::STAB_CYCLES
) (
   input  wire logic                        sys_clk_i,
   input  wire logic                        reset_n_i,
   input  wire logic [tlic_pkg::ADDR_W-1:0] paddr_i,
   input  wire logic                        psel_i,
   input  wire logic                        penable_i,
   input  wire logic                        pwrite_i,
   input  wire logic [31:0]                 pwdata_i,
   output logic [31:0]                      prdata_o,
   output logic                             pready_o,
   output logic                             pslverr_o,
   input  wire logic                        ext0_request_flag_i,
   input  wire logic                        timer0_overflow_flag_i,
   input  wire logic                        ext1_request_flag_i,
   input  wire logic                        timer1_overflow_flag_i,
   input  wire logic                        serial_receive_done_flag_i,
   input  wire logic                        serial_transmit_done_flag_i,
   input  wire logic                        timer2_overflow_flag_i,
   input  wire logic                        timer2_external_trigger_flag_i,
   input  wire logic                        converter_done_flag_i,
   input  wire logic                        ext2_request_flag_i,
   input  wire logic                        trap_event_flag_i,
   input  wire logic                        block_commutation_error_flag_i,
   input  wire logic                        compare_timer2_period_flag_i,
   input  wire logic [5:0]                  channel_match_flags_i,
   input  wire logic                        compare_timer1_period_flag_i,
   input  wire logic                        compare_timer1_compare_flag_i,
   input  wire logic                        external_request_pin_0_i,
   input  wire logic                        osc_above_rc_i,
   output logic                             irq_req_o,
   output logic [15:0]                      irq_vector_o,
   output logic                             irq_level_o,
   input  wire logic                        irq_ack_i,
   input  wire logic                        irq_return_i,
   output logic [tlic_pkg::NSRC:0]          served_src_o,
   output logic                             core_run_o
);
   localparam int N      = tlic_pkg::NSRC;
   localparam int STAB_W = $clog2(STAB_CYCLES + 1);

   if (STAB_CYCLES < 1) begin : g_chk
      $error("stabilisation count must be at least one cycle");
   end

   tlic_pkg::tlic_mode_e mode_reg;
   tlic_pkg::tlic_disp_e disp_reg;
   logic [N-1:0]         enable_reg;
   logic                 global_reg;
   logic [N-1:0]         level_reg;
   logic                 act_hi_reg;
   logic                 act_lo_reg;
   logic                 pd_pend_reg;
   logic [tlic_pkg::SRC_W-1:0] src_reg;
   logic [STAB_W-1:0]    stab_cnt_reg;
   logic [31:0]          rdata_reg;
   logic                 err_reg;
   logic [N-1:0]         raw;
   logic [N-1:0]         elig;
   logic                 hi_v;
   logic                 lo_v;
   logic [tlic_pkg::SRC_W-1:0] hi_idx;
   logic [tlic_pkg::SRC_W-1:0] lo_idx;
   logic                 use_hi;
   logic                 use_lo;
   logic                 grant;
   logic                 take;
   logic [tlic_pkg::SRC_W-1:0] cand_src;
   logic                 pin0_s;
   logic                 osc_ok_s;
   logic                 wr_en;
   logic                 setup;

   function automatic logic is_mapped(input logic [tlic_pkg::ADDR_W-1:0] a);
      return a == tlic_pkg::OFF_ENABLE || a == tlic_pkg::OFF_LEVEL ||
             a == tlic_pkg::OFF_MODE || a == tlic_pkg::OFF_STATUS ||
             a == tlic_pkg::OFF_VECTOR;
   endfunction

   // pins from outside the clock domain
   tlic_sync #(.RESET_VAL(1'b1)) u_pin0_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (external_request_pin_0_i),
      .sync_o    (pin0_s)
   );

   tlic_sync #(.RESET_VAL(1'b0)) u_osc_sync (
      .sys_clk_i (sys_clk_i),
      .reset_n_i (reset_n_i),
      .async_i   (osc_above_rc_i),
      .sync_o    (osc_ok_s)
   );

   always_comb begin
      raw     = '0;
      raw[0]  = ext0_request_flag_i;
      raw[1]  = timer0_overflow_flag_i;
      raw[2]  = ext1_request_flag_i;
      raw[3]  = timer1_overflow_flag_i;
      raw[4]  = serial_receive_done_flag_i | serial_transmit_done_flag_i;
      raw[5]  = timer2_overflow_flag_i | timer2_external_trigger_flag_i;
      raw[6]  = converter_done_flag_i;
      raw[7]  = ext2_request_flag_i;
      raw[8]  = trap_event_flag_i | block_commutation_error_flag_i;
      raw[9]  = compare_timer2_period_flag_i;
      raw[10] = |channel_match_flags_i;
      raw[11] = compare_timer1_period_flag_i | compare_timer1_compare_flag_i;
   end

   assign elig = raw & enable_reg & {N{global_reg}};

   tlic_arbiter #(.N(N)) u_arb_hi (
      .mask_i  (elig & level_reg),
      .valid_o (hi_v),
      .idx_o   (hi_idx)
   );

   tlic_arbiter #(.N(N)) u_arb_lo (
      .mask_i  (elig & ~level_reg),
      .valid_o (lo_v),
      .idx_o   (lo_idx)
   );

   // the wake-up request is polled ahead of all high-level sources
   // nothing passes high
   always_comb begin
      use_hi   = !act_hi_reg && (pd_pend_reg || hi_v);
      use_lo   = !use_hi && !act_hi_reg && !act_lo_reg && lo_v;
      cand_src = pd_pend_reg ? tlic_pkg::SRC_PD : (use_hi ? hi_idx : lo_idx);
   end

   assign grant = disp_reg == tlic_pkg::D_WAIT && mode_reg == tlic_pkg::M_RUN &&
                  (use_hi || use_lo);
   assign take  = disp_reg == tlic_pkg::D_REQ && irq_ack_i;

   // dispatch handshake; a request stands until the core takes it
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         disp_reg     <= tlic_pkg::D_WAIT;
         src_reg      <= '0;
         irq_vector_o <= '0;
         irq_level_o  <= 1'b0;
      end else begin
         unique case (disp_reg)
            tlic_pkg::D_WAIT: begin
               if (grant) begin
                  disp_reg     <= tlic_pkg::D_REQ;
                  src_reg      <= cand_src;
                  irq_vector_o <= tlic_pkg::VEC[cand_src];
                  irq_level_o  <= use_hi;
               end
            end
            tlic_pkg::D_REQ: begin
               if (irq_ack_i) begin
                  disp_reg <= tlic_pkg::D_WAIT;
               end
            end
         endcase
      end
   end

   assign irq_req_o = disp_reg == tlic_pkg::D_REQ;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         served_src_o <= '0;
      end else begin
         served_src_o <= '0;
         if (take) begin
            served_src_o[src_reg] <= 1'b1;
         end
      end
   end

   // level record
   // a return closes the newest routine; a same-cycle take still sets its level
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         act_hi_reg <= 1'b0;
         act_lo_reg <= 1'b0;
      end else begin
         if (irq_return_i && act_hi_reg) begin
            act_hi_reg <= 1'b0;
         end else if (irq_return_i) begin
            act_lo_reg <= 1'b0;
         end
         if (take && irq_level_o) begin
            act_hi_reg <= 1'b1;
         end
         if (take && !irq_level_o) begin
            act_lo_reg <= 1'b1;
         end
      end
   end

   // wake-up request
   // set at the end of stabilisation wins over a clear
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pd_pend_reg <= 1'b0;
      end else if (mode_reg == tlic_pkg::M_STAB && stab_cnt_reg == '0) begin
         pd_pend_reg <= 1'b1;
      end else if (take && src_reg == tlic_pkg::SRC_PD) begin
         pd_pend_reg <= 1'b0;
      end
   end

   // state kept on wake
   // power modes only gate the core; nothing else is reset on the way out
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         mode_reg     <= tlic_pkg::M_RUN;
         stab_cnt_reg <= '0;
      end else begin
         unique case (mode_reg)
            tlic_pkg::M_RUN: begin
               if (wr_en && paddr_i == tlic_pkg::OFF_MODE) begin
                  if (pwdata_i[tlic_pkg::MODE_PD_BIT]) begin
                     mode_reg <= tlic_pkg::M_PD;
                  end else if (pwdata_i[tlic_pkg::MODE_IDLE_BIT]) begin
                     mode_reg <= tlic_pkg::M_IDLE;
                  end
               end
            end
            tlic_pkg::M_IDLE: begin
               if (hi_v || lo_v || pd_pend_reg) begin
                  mode_reg <= tlic_pkg::M_RUN;
               end
            end
            tlic_pkg::M_PD: begin
               if (!pin0_s) begin
                  mode_reg <= tlic_pkg::M_OSC;
               end
            end
            tlic_pkg::M_OSC: begin
               if (osc_ok_s) begin
                  mode_reg     <= tlic_pkg::M_STAB;
                  stab_cnt_reg <= STAB_W'(STAB_CYCLES - 1);
               end
            end
            tlic_pkg::M_STAB: begin
               if (stab_cnt_reg == '0) begin
                  mode_reg <= tlic_pkg::M_RUN;
               end else begin
                  stab_cnt_reg <= stab_cnt_reg - 1'b1;
               end
            end
            default: begin
               mode_reg <= tlic_pkg::M_RUN;
            end
         endcase
      end
   end

   assign core_run_o = mode_reg == tlic_pkg::M_RUN;

   // apb slave: data and error are prepared in setup, so access has no wait
   assign setup     = psel_i && !penable_i;
   assign wr_en     = psel_i && penable_i && pwrite_i && !err_reg;
   assign pready_o  = 1'b1;
   assign prdata_o  = rdata_reg;
   assign pslverr_o = psel_i && penable_i && err_reg;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_reg <= '0;
         err_reg   <= 1'b0;
      end else if (setup) begin
         err_reg   <= !is_mapped(paddr_i);
         rdata_reg <= '0;
         unique case (paddr_i)
            tlic_pkg::OFF_ENABLE: begin
               rdata_reg[N-1:0]                    <= enable_reg;
               rdata_reg[tlic_pkg::EN_GLOBAL_BIT]  <= global_reg;
            end
            tlic_pkg::OFF_LEVEL: begin
               rdata_reg[N-1:0] <= level_reg;
            end
            tlic_pkg::OFF_MODE: begin
               rdata_reg[tlic_pkg::MODE_IDLE_BIT] <= mode_reg == tlic_pkg::M_IDLE;
               rdata_reg[tlic_pkg::MODE_PD_BIT]   <= mode_reg == tlic_pkg::M_PD;
               rdata_reg[tlic_pkg::MODE_WAKE_BIT] <= mode_reg == tlic_pkg::M_OSC ||
                                                     mode_reg == tlic_pkg::M_STAB;
            end
            tlic_pkg::OFF_STATUS: begin
               rdata_reg[N-1:0]                    <= raw;
               rdata_reg[tlic_pkg::ST_PD_BIT]      <= pd_pend_reg;
               rdata_reg[tlic_pkg::ST_ACT_LO_BIT]  <= act_lo_reg;
               rdata_reg[tlic_pkg::ST_ACT_HI_BIT]  <= act_hi_reg;
            end
            tlic_pkg::OFF_VECTOR: begin
               rdata_reg[15:0] <= irq_vector_o;
            end
            default: begin
               rdata_reg <= '0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enable_reg <= tlic_pkg::ENABLE_RST;
         global_reg <= tlic_pkg::GLOBAL_RST;
         level_reg  <= tlic_pkg::LEVEL_RST;
      end else if (wr_en && paddr_i == tlic_pkg::OFF_ENABLE) begin
         enable_reg <= pwdata_i[N-1:0];
         global_reg <= pwdata_i[tlic_pkg::EN_GLOBAL_BIT];
      end else if (wr_en && paddr_i == tlic_pkg::OFF_LEVEL) begin
         level_reg <= pwdata_i[N-1:0];
      end
   end

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);

   property p_hi_blocks;
      act_hi_reg |-> !grant;
   endproperty
   a_hi_blocks : assert property (p_hi_blocks)
      else $error("grant while a high routine is active");

   property p_lo_only_hi;
      act_lo_reg && grant |=> irq_level_o;
   endproperty
   a_lo_only_hi : assert property (p_lo_only_hi)
      else $error("low request preempted a low routine");

   property p_hi_first;
      grant && hi_v && lo_v && !pd_pend_reg |=> irq_level_o && level_reg[src_reg];
   endproperty
   a_hi_first : assert property (p_hi_first)
      else $error("low request won over a high one");

   property p_vector;
      irq_req_o |-> irq_vector_o == tlic_pkg::VEC[src_reg];
   endproperty
   a_vector : assert property (p_vector)
      else $error("vector does not match the source");

   property p_enabled;
      grant && !pd_pend_reg |-> global_reg && enable_reg[cand_src];
   endproperty
   a_enabled : assert property (p_enabled)
      else $error("disabled source granted");

   property p_idle_wake;
      mode_reg == tlic_pkg::M_IDLE && !irq_req_o && !act_hi_reg &&
         (hi_v || lo_v && !act_lo_reg) |=> core_run_o ##1 irq_req_o;
   endproperty
   a_idle_wake : assert property (p_idle_wake)
      else $error("enabled request did not end idle");

   property p_osc_wait;
      mode_reg == tlic_pkg::M_OSC && !osc_ok_s |=> mode_reg == tlic_pkg::M_OSC;
   endproperty
   a_osc_wait : assert property (p_osc_wait)
      else $error("left oscillator wait early");

   property p_wake_vec;
      mode_reg == tlic_pkg::M_STAB ##1 (core_run_o && !act_hi_reg && !irq_req_o)
         |-> pd_pend_reg ##1 irq_vector_o == tlic_pkg::VEC[tlic_pkg::SRC_PD];
   endproperty
   a_wake_vec : assert property (p_wake_vec)
      else $error("wake-up vector not dispatched");

   property p_return_only;
      $fell(act_hi_reg) || $fell(act_lo_reg) |-> $past(irq_return_i);
   endproperty
   a_return_only : assert property (p_return_only)
      else $error("level record cleared without a return");

   property p_pick_valid;
      (!hi_v || (elig[hi_idx] && level_reg[hi_idx])) &&
         (!lo_v || (elig[lo_idx] && !level_reg[lo_idx]));
   endproperty
   a_pick_valid : assert property (p_pick_valid)
      else $error("arbiter picked an idle source");
endmodule // tlic_top
`default_nettype wire

// *** test/test_two_level_interrupt_controller.sv ***
// self-checking bench of the two-level interrupt controller
`default_nettype none
module test_two_level_interrupt_controller;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, req, lvl, ack, run;
   logic [11:0] fl = 12'h000;
   logic alt = 1'b0, pin0 = 1'b1, osc = 1'b0, ret = 1'b0;
   logic [3:0] dly = 4'h0;
   logic [15:0] vec, last_vec;
   logic [12:0] srv;
   int n_fail = 0, tests_run = 0, cyc = 0;
   // highest first inside one level
   localparam logic [47:0] ORDER = 48'h061728394a5b;
   localparam logic [15:0] EXP_VEC [13] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b,
      16'h0023, 16'h002b, 16'h0043, 16'h004b, 16'h0053, 16'h005b, 16'h0063, 16'h006b,
      16'h007b};

   always #2 clk = ~clk;

   tlic_top #(.STAB_CYCLES(8)) tlic_top_i (
      .sys_clk_i(clk), .reset_n_i(rst_n), .paddr_i(paddr), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ext0_request_flag_i(fl[0]),
      .timer0_overflow_flag_i(fl[1]), .ext1_request_flag_i(fl[2]),
      .timer1_overflow_flag_i(fl[3]), .serial_receive_done_flag_i(fl[4] & !alt),
      .serial_transmit_done_flag_i(fl[4] & alt), .timer2_overflow_flag_i(fl[5] & !alt),
      .timer2_external_trigger_flag_i(fl[5] & alt), .converter_done_flag_i(fl[6]),
      .ext2_request_flag_i(fl[7]), .trap_event_flag_i(fl[8] & !alt),
      .block_commutation_error_flag_i(fl[8] & alt), .compare_timer2_period_flag_i(fl[9]),
      .channel_match_flags_i(alt ? {fl[10], 5'h00} : {5'h00, fl[10]}),
      .compare_timer1_period_flag_i(fl[11] & !alt),
      .compare_timer1_compare_flag_i(fl[11] & alt), .external_request_pin_0_i(pin0),
      .osc_above_rc_i(osc), .irq_req_o(req), .irq_vector_o(vec), .irq_level_o(lvl),
      .irq_ack_i(ack), .irq_return_i(ret), .served_src_o(srv), .core_run_o(run));

   tlic_core_model tlic_core_model_i (.clk_i(clk), .reset_n_i(rst_n), .req_i(req),
      .vec_i(vec), .delay_i(dly), .ack_o(ack), .last_vec_o(last_vec));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wait_hi(input logic on_run);
      int k;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while ((on_run ? run : req) !== 1'b1 && k < 300);
      chk(32'(on_run ? run : req), 32'h1);
   endtask

   task automatic quiet(input int n);
      repeat (n) begin
         @(posedge clk);
         chk(32'(req), 32'h0);
      end
   endtask

   task automatic ret_pulse();
      @(posedge clk);
      ret <= 1'b1;
      @(posedge clk);
      ret <= 1'b0;
   endtask

   // wait for a dispatch, judge it, let the core take it, then clear the flag
   task automatic serve(input logic [15:0] v, input logic l, input int idx, input bit r);
      int k;
      wait_hi(1'b0);
      chk(32'(vec), 32'(v));
      chk(32'(lvl), 32'(l));
      k = 0;
      while (req !== 1'b0 && k < 50) begin
         @(posedge clk);
         k++;
      end
      chk(32'(last_vec), 32'(v));
      chk(32'(srv), 32'h1 << idx);
      if (idx < 12) fl[idx] <= 1'b0;
      if (r) ret_pulse();
   endtask

   task automatic t_regs();
      apb(tlic_pkg::OFF_ENABLE, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(tlic_pkg::OFF_LEVEL, 1'b0, 32'h0);
      chk(rd, 32'h0);
      apb(8'h40, 1'b0, 32'h0);
      chk(32'(err), 32'h1);
      apb(tlic_pkg::OFF_ENABLE, 1'b1, 32'h1fff);
      apb(tlic_pkg::OFF_ENABLE, 1'b0, 32'h0);
      chk(rd, 32'h1fff);
      $display("test regs done");
   endtask

   task automatic t_poll(input logic a);
      int idx;
      alt <= a;
      fl <= 12'hfff;
      for (int i = 0; i < 12; i++) begin
         idx = int'(ORDER[47 - 4 * i -: 4]);
         serve(EXP_VEC[idx], 1'b0, idx, 1'b1);
      end
      $display("test poll done");
   endtask

   task automatic t_nest();
      dly <= 4'h3;
      apb(tlic_pkg::OFF_LEVEL, 1'b1, 32'h003);
      fl[7] <= 1'b1;
      serve(16'h004b, 1'b0, 7, 1'b0);
      fl[6] <= 1'b1;
      fl[1] <= 1'b1;
      serve(16'h000b, 1'b1, 1, 1'b0);
      fl[0] <= 1'b1;
      quiet(10);
      ret_pulse();
      serve(16'h0003, 1'b1, 0, 1'b1);
      quiet(10);
      ret_pulse();
      serve(16'h0043, 1'b0, 6, 1'b1);
      dly <= 4'h0;
      $display("test nest done");
   endtask

   task automatic t_simul();
      apb(tlic_pkg::OFF_LEVEL, 1'b1, 32'h008);
      fl <= 12'h009;
      serve(16'h001b, 1'b1, 3, 1'b1);
      serve(16'h0003, 1'b0, 0, 1'b1);
      apb(tlic_pkg::OFF_ENABLE, 1'b1, 32'h0fff);
      fl[2] <= 1'b1;
      quiet(8);
      apb(tlic_pkg::OFF_ENABLE, 1'b1, 32'h1ffb);
      quiet(8);
      apb(tlic_pkg::OFF_ENABLE, 1'b1, 32'h1fff);
      serve(16'h0013, 1'b0, 2, 1'b1);
      apb(tlic_pkg::OFF_VECTOR, 1'b0, 32'h0);
      chk(rd, 32'h0013);
      $display("test simul done");
   endtask

   task automatic t_power();
      apb(tlic_pkg::OFF_MODE, 1'b1, 32'h2);
      quiet(2);
      chk(32'(run), 32'h0);
      apb(tlic_pkg::OFF_MODE, 1'b0, 32'h0);
      chk(rd, 32'h2);
      pin0 <= 1'b0;
      quiet(10);
      chk(32'(run), 32'h0);
      osc <= 1'b1;
      wait_hi(1'b1);
      pin0 <= 1'b1;
      serve(16'h007b, 1'b1, 12, 1'b1);
      apb(tlic_pkg::OFF_ENABLE, 1'b0, 32'h0);
      chk(rd, 32'h1fff);
      apb(tlic_pkg::OFF_MODE, 1'b1, 32'h1);
      quiet(2);
      chk(32'(run), 32'h0);
      fl[9] <= 1'b1;
      wait_hi(1'b1);
      serve(16'h005b, 1'b0, 9, 1'b1);
      $display("test power done");
   endtask

   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ceiling well above the few hundred cycles the tests need
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_regs();
      t_poll(1'b0);
      t_poll(1'b1);
      t_nest();
      t_simul();
      t_power();
      report_and_stop();
   end
endmodule // test_two_level_interrupt_controller
`default_nettype wire

// *** test/tlic_core_model.sv ***
// core-side model: takes dispatch requests after a set delay and logs the vector
`default_nettype none
module tlic_core_model (
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        req_i,
   input  wire logic [15:0] vec_i,
   input  wire logic [3:0]  delay_i,
   output logic             ack_o,
   output logic [15:0]      last_vec_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] cnt;
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ack_o <= 1'b0;
         cnt <= 4'h0;
         last_vec_o <= 16'h0000;
      end else if (ack_o || !req_i) begin
         ack_o <= 1'b0;
         cnt <= 4'h0;
      end else if (cnt == delay_i) begin
         ack_o <= 1'b1;
         last_vec_o <= vec_i;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule // tlic_core_model
`default_nettype wire
